// ===== tdm_mem_module.sv
/*
  Tile data memory: eight protected banks with round-robin arbiters,
  four descriptor-driven DMA channels with word FIFOs, and a lock unit.
  Assumes requesters hold a request until granted; DEPTH a power of two.
*/
`timescale 1ns/10ps
// What this block does
// (R01) Eight single-port banks of 256x128 bits
// (R02) Per-word write enables inside each row
// (R03) ECC on banks 0-1, parity elsewhere
// (R04) Bank zero at offset zero, ascending
// (R05) Per word: correct single, detect double
// (R06) Round-robin arbiter per bank, no starvation
// (R07) One grant per bank per cycle
// (R08) Losers stall, request retried next cycle
// (R09) Two load, one store 256-bit ports
// (R10) Accept only requests steered to this module
// (R11) Two stream-in, two stream-out 32-bit channels
// (R12) Sixteen shared descriptors written from outside
// (R13) Descriptor may chain to a successor
// (R14) Optional lock acquire and release per descriptor
// (R15) Sixteen binary locks
// (R16) Round-robin arbiter per lock
// (R17) Total storage 32 KB over eight banks
// (R18) Acquire waits until lock holds expected value
// (R19) Uncorrectable or parity error raises event
module tdm_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Fill side
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } tdm_fifo_st_t;
  tdm_fifo_st_t q, n;
  logic [W-1:0] mem [DEPTH];
  logic push, pop;

  always_comb begin
    n = q;
    in_ready = q.cnt != (AW+1)'(DEPTH);
    out_valid = q.cnt != '0;
    out_data = mem[q.rp];
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    if (push) n.wp = q.wp + 1'b1;
    if (pop) n.rp = q.rp + 1'b1;
    n.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk) begin
    if (!nrst) q <= '0;
    else q <= n;
  end

  always_ff @(posedge clk) begin
    if (push) mem[q.wp] <= in_data;
  end
endmodule

module tdm_mem_module #(
  parameter logic [1:0] MY_DIR = 2'h0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Core load and store ports
  input wire tdm_pkg::tdm_mem_req_t core_req [tdm_pkg::NCP],
  output logic [tdm_pkg::NCP-1:0] core_gnt,
  output tdm_pkg::tdm_mem_rsp_t core_rsp [tdm_pkg::NCP],
  // Lock requests: cores, then memory-mapped master
  input wire tdm_pkg::tdm_lock_req_t lk_req [tdm_pkg::NCORE+1],
  output logic [tdm_pkg::NCORE:0] lk_gnt,
  // Descriptor writes
  input wire logic bd_we,
  input wire logic [3:0] bd_idx,
  input wire tdm_pkg::tdm_bd_t bd_wdata,
  // DMA channel control
  input wire logic [tdm_pkg::NCH-1:0] ch_start,
  input wire logic [tdm_pkg::NCH-1:0][3:0] ch_bd_sel,
  output logic [tdm_pkg::NCH-1:0] ch_busy,
  // Stream to memory
  input wire tdm_pkg::tdm_word_t stm_in [tdm_pkg::NSTM],
  output logic [tdm_pkg::NSTM-1:0] stm_ready,
  // Memory to stream
  output tdm_pkg::tdm_word_t mts_out [tdm_pkg::NSTM],
  input wire logic [tdm_pkg::NSTM-1:0] mts_ready,
  // Error event
  output logic err_event
);
  localparam int NR = tdm_pkg::NREQ;
  localparam int NCP = tdm_pkg::NCP;
  localparam int NCH = tdm_pkg::NCH;
  localparam int NB = tdm_pkg::NBANK;
  localparam int CW = tdm_pkg::CODE_W;
  localparam int LK0 = tdm_pkg::NCORE + 1;

  typedef struct packed {
    logic [NB-1:0][3:0] bptr;
    logic [tdm_pkg::NLOCK-1:0][3:0] lptr;
    logic [tdm_pkg::NLOCK-1:0] lval;
    logic [tdm_pkg::NLOCK-1:0] lheld;
    tdm_pkg::tdm_bd_t [tdm_pkg::NBD-1:0] bd;
    logic [NR-1:0] rpend;
    logic [NR-1:0][2:0] rbank;
    logic [NR-1:0][1:0] rsel;
    tdm_pkg::tdm_ch_state_t [NCH-1:0] cst;
    logic [NCH-1:0][3:0] cbd;
    logic [NCH-1:0][tdm_pkg::WADDR_W-1:0] caddr;
    logic [NCH-1:0][tdm_pkg::WADDR_W-1:0] cleft;
    logic [NCH-1:0] clast;
    logic [NCP-1:0] rsp_v;
    logic [NCP-1:0] rsp_e;
    logic [NCP-1:0][tdm_pkg::CORE_W-1:0] rsp_d;
    logic err;
  } tdm_state_t;

  // ----------------------------------------------------------------
  // Code functions
  // ----------------------------------------------------------------
  function automatic logic [5:0] ham(input logic [31:0] d);
    logic [5:0] c;
    logic [5:0] p;
    c = '0;
    p = 6'h02;
    for (int i = 0; i < 32; i++) begin
      p = p + 6'h01;
      if ((p & (p - 6'h01)) == 6'h00) p = p + 6'h01;
      if (d[i]) c = c ^ p;
    end
    return c;
  endfunction

  function automatic logic [6:0] enc(input logic [31:0] d, input logic ecc);
    logic [5:0] h;
    h = ham(d);
    return ecc ? {^{d, h}, h} : {6'h00, ^d};
  endfunction

  function automatic logic [32:0] dec(input logic [CW-1:0] w, input logic ecc);
    logic [31:0] d;
    logic [5:0] s;
    logic [5:0] p;
    logic pe;
    d = w[31:0];
    s = w[37:32] ^ ham(d);
    pe = ^w;
    p = 6'h02;
    if (!ecc) return {pe, d};
    for (int i = 0; i < 32; i++) begin
      p = p + 6'h01;
      if ((p & (p - 6'h01)) == 6'h00) p = p + 6'h01;
      if (pe && s == p) d[i] = ~d[i];
    end
    return {!pe && s != 6'h00, d};
  endfunction

  function automatic logic [4:0] rr_pick(input logic [15:0] v, input logic [3:0] ptr);
    logic [4:0] res;
    logic [3:0] k;
    res = '0;
    for (int i = 15; i >= 0; i--) begin
      k = ptr + 4'(i);
      if (v[k]) res = {1'b1, k};
    end
    return res;
  endfunction

  tdm_state_t q, n;
  logic [NR-1:0] iv, iwe, gnt, rerr;
  logic [NR-1:0][2:0] ibank;
  logic [NR-1:0][7:0] irow;
  logic [NR-1:0][1:0] isel;
  logic [NR-1:0][3:0] istrb;
  logic [NR-1:0][tdm_pkg::ROW_W-1:0] iwd;
  logic [NB-1:0] bk_en, bk_we;
  logic [NB-1:0][7:0] bk_row;
  logic [NB-1:0][3:0] bk_strb;
  logic [NB-1:0][4*CW-1:0] bk_code;
  logic [4*CW-1:0] mem [NB][tdm_pkg::ROWS];
  logic [4*CW-1:0] rd_row [NB];
  logic [NB-1:0][tdm_pkg::ROW_W-1:0] dec_row;
  logic [NB-1:0] dec_err;
  logic [15:0] bv, lv;
  logic [4:0] pk;
  logic [32:0] dw;
  tdm_pkg::tdm_lock_req_t lr [tdm_pkg::NLREQ];
  logic [tdm_pkg::NLREQ-1:0] lg;
  logic [NCH-1:0] fin, ld;
  logic [NCH-1:0][3:0] ldi;
  logic [NCH-1:0] fin_v, fin_r, fout_v, fout_r;
  logic [NCH-1:0][tdm_pkg::WORD_W-1:0] fin_d, fout_d;

  // ----------------------------------------------------------------
  // Channel FIFOs
  // ----------------------------------------------------------------
  for (genvar c = 0; c < NCH; c++) begin : g_fifo
    tdm_fifo #(.W(tdm_pkg::WORD_W), .DEPTH(tdm_pkg::FIFO_DEPTH)) u_tdm_fifo (
      .clk(clk),
      .nrst(nrst),
      .in_valid(fin_v[c]),
      .in_data(fin_d[c]),
      .in_ready(fin_r[c]),
      .out_valid(fout_v[c]),
      .out_data(fout_d[c]),
      .out_ready(fout_r[c])
    );
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    n = q;
    gnt = '0;
    lg = '0;
    bk_en = '0;
    bk_we = '0;
    bk_row = '0;
    bk_strb = '0;
    bk_code = '0;
    dec_row = '0;
    dec_err = '0;
    rerr = '0;
    fin = '0;
    ld = '0;
    ldi = ch_bd_sel;
    fin_v = '0;
    fin_d = '0;
    fout_r = '0;
    bv = '0;
    lv = '0;
    pk = '0;
    dw = '0;
    // Core ports: 128-bit beat in the half that its address selects
    for (int r = 0; r < NCP; r++) begin
      iv[r] = core_req[r].valid && core_req[r].addr[tdm_pkg::DIR_LSB +: 2] == MY_DIR; // [R10]
      iwe[r] = core_req[r].we;
      ibank[r] = core_req[r].addr[tdm_pkg::BANK_LSB +: 3]; // [R04]
      irow[r] = core_req[r].addr[tdm_pkg::ROW_LSB +: 8];
      isel[r] = {1'b0, core_req[r].addr[tdm_pkg::HALF_BIT]};
      istrb[r] = isel[r][0] ? core_req[r].strb[7:4] : core_req[r].strb[3:0]; // [R02]
      iwd[r] = isel[r][0] ? core_req[r].wdata[255:128] : core_req[r].wdata[127:0]; // [R09]
    end
    // DMA ports: one 32-bit word per access
    for (int c = 0; c < NCH; c++) begin
      iwe[NCP+c] = c < tdm_pkg::NSTM;
      ibank[NCP+c] = q.caddr[c][12:10];
      irow[NCP+c] = q.caddr[c][9:2];
      isel[NCP+c] = q.caddr[c][1:0];
      istrb[NCP+c] = 4'h1 << q.caddr[c][1:0];
      iwd[NCP+c] = {4{fout_d[c]}};
      iv[NCP+c] = q.cst[c] == tdm_pkg::TDM_CH_MOVE && !q.clast[c]
        && (c < tdm_pkg::NSTM ? fout_v[c] : !q.rpend[NCP+c] && fin_r[c]);
    end
    // Bank arbitration and write encoding
    for (int b = 0; b < NB; b++) begin
      for (int r = 0; r < NR; r++) bv[r] = iv[r] && ibank[r] == 3'(b);
      pk = rr_pick(bv, q.bptr[b]); // [R06]
      if (pk[4]) begin
        gnt[pk[3:0]] = 1'b1; // [R07]
        n.bptr[b] = pk[3:0] + 4'h1;
        bk_en[b] = 1'b1;
        bk_we[b] = iwe[pk[3:0]];
        bk_row[b] = irow[pk[3:0]];
        bk_strb[b] = istrb[pk[3:0]];
        for (int l = 0; l < 4; l++) begin
          bk_code[b][l*CW +: CW] = {enc(iwd[pk[3:0]][l*32 +: 32], b < tdm_pkg::ECC_BANKS), // [R03]
            iwd[pk[3:0]][l*32 +: 32]};
        end
      end
      for (int l = 0; l < 4; l++) begin
        dw = dec(rd_row[b][l*CW +: CW], b < tdm_pkg::ECC_BANKS); // [R05]
        dec_row[b][l*32 +: 32] = dw[31:0];
        dec_err[b] = dec_err[b] | dw[32];
      end
    end
    core_gnt = gnt[NCP-1:0]; // [R08]
    // Read returns
    for (int r = 0; r < NR; r++) begin
      n.rpend[r] = gnt[r] && !iwe[r];
      n.rbank[r] = ibank[r];
      n.rsel[r] = isel[r];
      rerr[r] = q.rpend[r] && dec_err[q.rbank[r]];
    end
    for (int r = 0; r < NCP; r++) begin
      n.rsp_v[r] = q.rpend[r];
      n.rsp_e[r] = rerr[r];
      n.rsp_d[r] = q.rsel[r][0] ? {dec_row[q.rbank[r]], 128'h0} : {128'h0, dec_row[q.rbank[r]]};
    end
    n.err = |rerr; // [R19]
    // Lock requesters
    for (int k = 0; k < LK0; k++) lr[k] = lk_req[k];
    for (int c = 0; c < NCH; c++) begin
      lr[LK0+c].valid = q.cst[c] == tdm_pkg::TDM_CH_ACQ || q.cst[c] == tdm_pkg::TDM_CH_REL;
      lr[LK0+c].acq = q.cst[c] == tdm_pkg::TDM_CH_ACQ;
      lr[LK0+c].id = q.bd[q.cbd[c]].lock_id;
      lr[LK0+c].val = lr[LK0+c].acq ? q.bd[q.cbd[c]].acq_val : q.bd[q.cbd[c]].rel_val;
    end
    for (int l = 0; l < tdm_pkg::NLOCK; l++) begin
      lv = '0;
      for (int k = 0; k < tdm_pkg::NLREQ; k++) begin
        lv[k] = lr[k].valid && lr[k].id == 4'(l)
          && (!lr[k].acq || (!q.lheld[l] && q.lval[l] == lr[k].val)); // [R18]
      end
      pk = rr_pick(lv, q.lptr[l]); // [R16]
      if (pk[4]) begin
        lg[pk[3:0]] = 1'b1;
        n.lptr[l] = pk[3:0] + 4'h1;
        n.lheld[l] = lr[pk[3:0]].acq; // [R15]
        if (!lr[pk[3:0]].acq) n.lval[l] = lr[pk[3:0]].val;
      end
    end
    lk_gnt = lg[LK0-1:0];
    // DMA channels
    for (int c = 0; c < NCH; c++) begin
      unique case (q.cst[c])
        tdm_pkg::TDM_CH_IDLE: ld[c] = ch_start[c];
        tdm_pkg::TDM_CH_ACQ: if (lg[LK0+c]) n.cst[c] = tdm_pkg::TDM_CH_MOVE; // [R14]
        tdm_pkg::TDM_CH_MOVE: begin
          if (gnt[NCP+c]) begin
            n.caddr[c] = q.caddr[c] + 13'h0001;
            n.cleft[c] = q.cleft[c] - 13'h0001;
            n.clast[c] = q.cleft[c] == '0;
          end
          if (q.clast[c] && !q.rpend[NCP+c]) begin
            if (q.bd[q.cbd[c]].lock_en) n.cst[c] = tdm_pkg::TDM_CH_REL; // [R14]
            else fin[c] = 1'b1;
          end
        end
        tdm_pkg::TDM_CH_REL: fin[c] = lg[LK0+c];
      endcase
      if (fin[c]) begin
        ld[c] = q.bd[q.cbd[c]].next_en; // [R13]
        ldi[c] = q.bd[q.cbd[c]].next;
        n.cst[c] = tdm_pkg::TDM_CH_IDLE;
      end
      if (ld[c]) begin
        n.cbd[c] = ldi[c];
        n.caddr[c] = q.bd[ldi[c]].base;
        n.cleft[c] = q.bd[ldi[c]].len;
        n.clast[c] = 1'b0;
        n.cst[c] = q.bd[ldi[c]].lock_en ? tdm_pkg::TDM_CH_ACQ : tdm_pkg::TDM_CH_MOVE;
      end
      ch_busy[c] = q.cst[c] != tdm_pkg::TDM_CH_IDLE;
    end
    // Stream plumbing through the FIFOs
    for (int c = 0; c < tdm_pkg::NSTM; c++) begin
      fin_v[c] = stm_in[c].valid; // [R11]
      fin_d[c] = stm_in[c].data;
      stm_ready[c] = fin_r[c];
      fout_r[c] = gnt[NCP+c];
      fin_v[c+2] = q.rpend[NCP+c+2];
      fin_d[c+2] = dec_row[q.rbank[NCP+c+2]][q.rsel[NCP+c+2]*32 +: 32];
      fout_r[c+2] = mts_ready[c];
      mts_out[c].valid = fout_v[c+2];
      mts_out[c].data = fout_d[c+2];
    end
    if (bd_we) n.bd[bd_idx] = bd_wdata; // [R12]
    for (int r = 0; r < NCP; r++) core_rsp[r] = {q.rsp_v[r], q.rsp_e[r], q.rsp_d[r]};
    err_event = q.err;
  end

  always_ff @(posedge clk) begin
    if (!nrst) q <= '0;
    else q <= n;
  end

  // Banks: 256 rows x 4 coded words each, 4 KB of data per bank
  always_ff @(posedge clk) begin
    for (int b = 0; b < NB; b++) begin
      if (bk_en[b]) begin
        for (int l = 0; l < 4; l++) begin
          if (bk_we[b] && bk_strb[b][l]) mem[b][bk_row[b]][l*CW +: CW] <= bk_code[b][l*CW +: CW]; // [R01] [R17]
        end
        rd_row[b] <= mem[b][bk_row[b]];
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  logic gmulti;
  logic [15:0] gv;
  logic [4:0] wait0;
  always_comb begin
    gmulti = 1'b0;
    gv = '0;
    for (int b = 0; b < NB; b++) begin
      gv = '0;
      for (int r = 0; r < NR; r++) gv[r] = gnt[r] && ibank[r] == 3'(b);
      if ($countones(gv) > 1) gmulti = 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (!nrst || !iv[0] || gnt[0]) wait0 <= '0;
    else wait0 <= wait0 + 5'h01;
  end
  property p_r07; !gmulti; endproperty
  a_r07: assert property (p_r07) else $error("two grants on one bank"); // [R07]
  property p_r06; wait0 < 5'h10; endproperty
  a_r06: assert property (p_r06) else $error("requester starved"); // [R06]
  property p_r08; iv[0] && !gnt[0] |-> ##[1:15] (gnt[0] || !iv[0]); endproperty
  a_r08: assert property (p_r08) else $error("stalled request not retried"); // [R08]
  property p_r09; gnt[0] && !iwe[0] |-> ##2 core_rsp[0].valid; endproperty
  a_r09: assert property (p_r09) else $error("load answer not two cycles later"); // [R09]
  property p_r05;
    dec({enc(iwd[0][31:0], 1'b1), iwd[0][31:0]} ^ 39'h00_0000_0004, 1'b1) == {1'b0, iwd[0][31:0]};
  endproperty
  a_r05: assert property (p_r05) else $error("single error not corrected"); // [R05]
  property p_r19; |rerr |=> err_event; endproperty
  a_r19: assert property (p_r19) else $error("read error without event"); // [R19]
  property p_r18; lg[0] && lr[0].acq |-> q.lval[lr[0].id] == lr[0].val ##1 q.lheld[$past(lr[0].id)];
  endproperty
  a_r18: assert property (p_r18) else $error("acquire on wrong lock value"); // [R18]
  property p_r13; fin[0] && q.bd[q.cbd[0]].next_en |=> q.cbd[0] == $past(q.bd[q.cbd[0]].next);
  endproperty
  a_r13: assert property (p_r13) else $error("chain not followed"); // [R13]
  property p_r14; q.cst[0] == tdm_pkg::TDM_CH_ACQ && !lg[LK0] |=> q.cst[0] == tdm_pkg::TDM_CH_ACQ;
  endproperty
  a_r14: assert property (p_r14) else $error("moved without lock"); // [R14]
  property p_r12; bd_we |=> q.bd[$past(bd_idx)] == $past(bd_wdata); endproperty
  a_r12: assert property (p_r12) else $error("descriptor write lost"); // [R12]
  c_conflict: cover property (iv[0] && iv[1] && ibank[0] == ibank[1]);
  c_chain: cover property (fin[0] && ld[0]);
  c_lock: cover property (lg[LK0] && q.cst[0] == tdm_pkg::TDM_CH_ACQ);
endmodule

// ===== tdm_mem_module_bench.sv
/*
  Bench of the tile data memory: random rows, bank conflicts, locks,
  and a chained, lock-gated stream round trip through the DMA.
  Assumes the package, design and partner files are compiled first.
*/
`timescale 1ns/10ps
module tdm_mem_module_bench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  tdm_pkg::tdm_mem_req_t core_req [tdm_pkg::NCP];
  logic [tdm_pkg::NCP-1:0] core_gnt;
  tdm_pkg::tdm_mem_rsp_t core_rsp [tdm_pkg::NCP];
  tdm_pkg::tdm_lock_req_t lk_req [tdm_pkg::NCORE+1];
  logic [tdm_pkg::NCORE:0] lk_gnt;
  logic bd_we = 1'b0;
  logic [3:0] bd_idx = 4'h0;
  tdm_pkg::tdm_bd_t bd_wdata = '0;
  logic [tdm_pkg::NCH-1:0] ch_start = '0;
  logic [tdm_pkg::NCH-1:0][3:0] ch_bd_sel = '0;
  logic [tdm_pkg::NCH-1:0] ch_busy;
  tdm_pkg::tdm_word_t stm_in [tdm_pkg::NSTM];
  logic [tdm_pkg::NSTM-1:0] stm_ready;
  tdm_pkg::tdm_word_t mts_out [tdm_pkg::NSTM];
  logic [tdm_pkg::NSTM-1:0] mts_ready;
  logic err_event;
  logic [4:0] quota = 5'h00;
  logic [31:0] sh [8192];
  int fail_count = 0;
  int check_count = 0;
  tdm_pkg::tdm_mem_req_t rq;
  tdm_pkg::tdm_bd_t bd;
  logic ok;
  logic [12:0] wa;
  int k;
  int p;
  int na;
  int nb;

  always #20 clk = ~clk;

  tdm_mem_module #(.MY_DIR(2'h0)) u_tdm_mem_module (.clk(clk), .nrst(nrst),
    .core_req(core_req), .core_gnt(core_gnt), .core_rsp(core_rsp), .lk_req(lk_req),
    .lk_gnt(lk_gnt), .bd_we(bd_we), .bd_idx(bd_idx), .bd_wdata(bd_wdata),
    .ch_start(ch_start), .ch_bd_sel(ch_bd_sel), .ch_busy(ch_busy), .stm_in(stm_in),
    .stm_ready(stm_ready), .mts_out(mts_out), .mts_ready(mts_ready),
    .err_event(err_event));

  tdm_stream_partner u_tdm_stream_partner (.clk(clk), .nrst(nrst), .quota(quota),
    .stm_in(stm_in), .stm_ready(stm_ready), .mts_out(mts_out),
    .mts_ready(mts_ready));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic summarize();
    if (fail_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input logic [263:0] seen, input logic [263:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic expire(input logic done);
    if (done !== 1'b1) begin
      fail_count++;
      summarize();
    end
  endtask

  task automatic access(input int p, input logic we, input logic [12:0] wa,
                        input logic [3:0] sb, input logic [127:0] d);
    logic [255:0] e;
    int n;
    rq = '0;
    rq.valid = 1'b1;
    rq.we = we;
    rq.addr = {2'b00, wa, 2'b00};
    rq.strb[4*wa[2] +: 4] = sb;
    rq.wdata[128*wa[2] +: 128] = d;
    e = '0;
    for (int l = 0; l < 4; l++) begin
      if (we && sb[l]) sh[{wa[12:2], 2'(l)}] = d[32*l +: 32];
      e[128*wa[2] + 32*l +: 32] = sh[{wa[12:2], 2'(l)}];
    end
    @(posedge clk);
    core_req[p] <= rq;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (core_gnt[p] !== 1'b1 && n < 16);
    expire(core_gnt[p]);
    core_req[p] <= '0;
    if (!we) begin
      #1;
      check(core_rsp[p].valid, 1'b0);
      @(posedge clk);
      #1;
      check({core_rsp[p].valid, core_rsp[p].err, core_rsp[p].rdata}, {2'b10, e});
    end
  endtask

  task automatic lk_op(input int r, input logic acq, input logic [3:0] id,
                       input logic v, output logic g);
    int n;
    @(posedge clk);
    lk_req[r] <= '{1'b1, acq, id, v};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (lk_gnt[r] !== 1'b1 && n < 4);
    g = lk_gnt[r];
    lk_req[r] <= '0;
  endtask

  task automatic bd_put(input logic [3:0] i, input tdm_pkg::tdm_bd_t b);
    @(posedge clk);
    bd_we <= 1'b1;
    bd_idx <= i;
    bd_wdata <= b;
    @(posedge clk);
    bd_we <= 1'b0;
  endtask

  task automatic start_ch(input int c, input logic [3:0] b);
    @(posedge clk);
    ch_start[c] <= 1'b1;
    ch_bd_sel[c] <= b;
    @(posedge clk);
    ch_start[c] <= 1'b0;
  endtask

  always @(posedge clk) begin
    if (nrst && err_event !== 1'b0) check(err_event, 1'b0);
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(56));
    for (int i = 0; i < tdm_pkg::NCP; i++) core_req[i] = '0;
    for (int i = 0; i <= tdm_pkg::NCORE; i++) lk_req[i] = '0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    // Full write, partial overwrite, read back, random banks and both ends
    for (int i = 0; i < 24; i++) begin
      p = $urandom_range(3, 0) * 3;
      wa = (i == 0) ? 13'h0000 : (i == 1) ? 13'h1ffc : 13'($urandom) & 13'h1ffc;
      access(p + 2, 1'b1, wa, 4'hf, {$urandom, $urandom, $urandom, $urandom});
      access(p + 2, 1'b1, wa, 4'($urandom), {$urandom, $urandom, $urandom, $urandom});
      access(p + $urandom_range(1, 0), 1'b0, wa, 4'h0, '0);
    end
    // Other direction is never taken
    rq = '0;
    rq.valid = 1'b1;
    rq.addr = 17'h0_8000;
    @(posedge clk);
    core_req[1] <= rq;
    repeat (6) begin
      @(posedge clk);
      check(core_gnt[1], 1'b0);
    end
    core_req[1] <= '0;
    // Two stores held on one bank
    rq.addr = 17'h0_3000;
    rq.we = 1'b1;
    @(posedge clk);
    core_req[2] <= rq;
    rq.addr[11:4] = 8'h01;
    core_req[5] <= rq;
    na = 0;
    nb = 0;
    repeat (4) begin
      @(posedge clk);
      check(core_gnt[2] + core_gnt[5], 1);
      na += core_gnt[2];
      nb += core_gnt[5];
    end
    core_req[2] <= '0;
    core_req[5] <= '0;
    check(na, 2);
    check(nb, 2);
    // Every lock: hold, value match, release value
    for (int i = 0; i < 16; i++) begin
      p = i % 5;
      lk_op(p, 1'b1, 4'(i), 1'b0, ok);
      check(ok, 1'b1);
      lk_op((p + 1) % 5, 1'b1, 4'(i), 1'b0, ok);
      check(ok, 1'b0);
      lk_op(p, 1'b0, 4'(i), 1'b1, ok);
      check(ok, 1'b1);
      lk_op(p, 1'b1, 4'(i), 1'b0, ok);
      check(ok, 1'b0);
      lk_op(p, 1'b1, 4'(i), 1'b1, ok);
      check(ok, 1'b1);
      lk_op(p, 1'b0, 4'(i), 1'b0, ok);
    end
    @(posedge clk);
    lk_req[0] <= '{1'b1, 1'b1, 4'h3, 1'b0};
    lk_req[4] <= '{1'b1, 1'b1, 4'h3, 1'b0};
    @(posedge clk);
    check(lk_gnt[0] + lk_gnt[4], 1);
    lk_req[0] <= '0;
    lk_req[4] <= '0;
    lk_op(0, 1'b0, 4'h3, 1'b0, ok);
    // Chained, lock-gated stream into bank 1, then back out
    for (int i = 0; i < 3; i++) access(2, 1'b1, 13'h0400 + 13'(4 * i), 4'hf, '0);
    bd = '0;
    bd.base = 13'h0408;
    bd.len = 13'h0001;
    bd_put(4'h1, bd);
    bd.base = 13'h0400;
    bd.len = 13'h0009;
    bd_put(4'h2, bd);
    bd.len = 13'h0007;
    bd.next_en = 1'b1;
    bd.next = 4'h1;
    bd.lock_en = 1'b1;
    bd.lock_id = 4'h5;
    bd.acq_val = 1'b1;
    bd_put(4'h0, bd);
    quota <= 5'h0a;
    start_ch(0, 4'h0);
    repeat (60) @(posedge clk);
    check(ch_busy[0], 1'b1);
    check(stm_ready[0], 1'b0);
    check(u_tdm_stream_partner.sent_n, 5'h08);
    lk_op(3, 1'b0, 4'h5, 1'b1, ok);
    for (k = 0; k < 400 && ch_busy[0] !== 1'b0; k++) @(posedge clk);
    expire(ch_busy[0] === 1'b0);
    check(u_tdm_stream_partner.sent_n, 5'h0a);
    for (int i = 0; i < 10; i++) sh[13'h0400 + i] = u_tdm_stream_partner.sent[i];
    for (int i = 0; i < 3; i++) access(1, 1'b0, 13'h0400 + 13'(4 * i), 4'h0, '0);
    lk_op(4, 1'b1, 4'h5, 1'b0, ok);
    check(ok, 1'b1);
    lk_op(4, 1'b0, 4'h5, 1'b0, ok);
    start_ch(2, 4'h2);
    for (k = 0; k < 600 && u_tdm_stream_partner.got_n !== 5'h0a; k++) @(posedge clk);
    expire(u_tdm_stream_partner.got_n === 5'h0a);
    for (int i = 0; i < 10; i++) begin
      check(u_tdm_stream_partner.got[i], u_tdm_stream_partner.sent[i]);
    end
    check(mts_out[0].valid, 1'b0);
    summarize();
  end
endmodule

// ===== tdm_pkg.sv
/*
  Shared constants and carrier types of the tile data memory module.
  Assumes one core clock; all users reference names as tdm_pkg::name.
*/
package tdm_pkg;
  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int NBANK = 8;
  localparam int ROWS = 256;
  localparam int ROW_W = 128;
  localparam int LANES = 4;
  localparam int WORD_W = 32;
  localparam int CHK_W = 7;
  localparam int CODE_W = WORD_W + CHK_W;
  localparam int ECC_BANKS = 2;
  localparam int CORE_W = 256;
  localparam int NCORE = 4;
  localparam int CPORTS = 3;
  localparam int NCP = NCORE * CPORTS;
  localparam int NCH = 4;
  localparam int NSTM = 2;
  localparam int NREQ = NCP + NCH;
  localparam int NLOCK = 16;
  localparam int NLREQ = NCORE + 1 + NCH;
  localparam int NBD = 16;
  localparam int FIFO_DEPTH = 8;
  // ----------------------------------------------------------------
  // Address fields (byte address, core view; WADDR_W is the DMA word address width)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 17;
  localparam int DIR_LSB = 15;
  localparam int BANK_LSB = 12;
  localparam int ROW_LSB = 4;
  localparam int HALF_BIT = 4;
  localparam int WADDR_W = 13;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TDM_CH_IDLE = 2'b00,
    TDM_CH_ACQ = 2'b01,
    TDM_CH_MOVE = 2'b10,
    TDM_CH_REL = 2'b11
  } tdm_ch_state_t;
  typedef struct packed {
    logic valid;
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [7:0] strb;
    logic [CORE_W-1:0] wdata;
  } tdm_mem_req_t;
  typedef struct packed {
    logic valid;
    logic err;
    logic [CORE_W-1:0] rdata;
  } tdm_mem_rsp_t;
  typedef struct packed {
    logic valid;
    logic acq;
    logic [3:0] id;
    logic val;
  } tdm_lock_req_t;
  typedef struct packed {
    logic next_en;
    logic [3:0] next;
    logic lock_en;
    logic [3:0] lock_id;
    logic acq_val;
    logic rel_val;
    logic [WADDR_W-1:0] base;
    logic [WADDR_W-1:0] len;
  } tdm_bd_t;
  typedef struct packed {
    logic valid;
    logic [WORD_W-1:0] data;
  } tdm_word_t;
endpackage

// ===== tdm_stream_partner.sv
/*
  Stream partner: feeds stream-to-memory channel 0 and drains
  memory-to-stream channel 2, both with random stalls.
  Assumes the bench raises quota and reads sent and got by path.
*/
`timescale 1ns/10ps
module tdm_stream_partner (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Words to offer in total
  input wire logic [4:0] quota,
  // Stream to memory
  output tdm_pkg::tdm_word_t stm_in [tdm_pkg::NSTM],
  input wire logic [tdm_pkg::NSTM-1:0] stm_ready,
  // Memory to stream
  input wire tdm_pkg::tdm_word_t mts_out [tdm_pkg::NSTM],
  output logic [tdm_pkg::NSTM-1:0] mts_ready
);
  logic [31:0] sent [16];
  logic [31:0] got [16];
  logic [4:0] sent_n;
  logic [4:0] got_n;
  logic [4:0] n;
  always @(posedge clk) begin
    if (!nrst) begin
      sent_n <= '0;
      got_n <= '0;
      stm_in[0] <= '0;
      stm_in[1] <= '0;
      mts_ready <= 2'b00;
    end else begin
      // Unused lane keeps changing so stale data never looks valid
      stm_in[1].data <= ~stm_in[1].data;
      // Word offer held until taken
      if (!stm_in[0].valid || stm_ready[0]) begin
        n = sent_n + 5'(stm_in[0].valid);
        if (stm_in[0].valid) sent[sent_n] <= stm_in[0].data;
        sent_n <= n;
        stm_in[0].valid <= (n < quota) && $urandom_range(1, 0);
        stm_in[0].data <= (n < quota) ? $urandom : ~stm_in[0].data;
      end
      if (mts_out[0].valid && mts_ready[0]) begin
        got[got_n] <= mts_out[0].data;
        got_n <= got_n + 5'h01;
      end
      mts_ready[0] <= 1'($urandom_range(1, 0));
    end
  end
endmodule
